// [hdl/mrdsc_device.sv]
// Device end: run/halt and direction logic plus the serial configuration slave.
//
// Summary of operation
// [R1] Generator runs while run input low.
// [R2] Direction is input XOR stored setting.
// [R3] Master clocks; one bit per clock.
// [R4] Any master clock rate slower than a few system clocks is accepted.
// [R5] One driver on return line per transfer.
// [R6] Reads return stored parameter values.
// [R7] Writes capture new values from master.
// [R8] Serial activity only while selected.
// [R9] Master selects one unit per transfer.
// [R10] Deselected: ignore inputs, release return line.
//
// Frame, MSB first, mode 0 (sample on rising, shift on falling edge):
// bit 15 read flag, bits 14..8 slot index (low three bits used),
// A frame cut short by the select rising stores nothing.
// bits 7..0 data. On a read the device returns the slot value during
// bits 7..0; on a write the slot takes the data when bit 0 arrives.
module mrdsc_device (
  input  wire logic         clk,
  input  wire logic         reset,
  mrdsc_link_if.device      link,
  input  wire logic         run_halt_n,
  input  wire logic         dir_in,
  input  wire logic         step_tick,
  output logic              step_enable,
  output logic              step_pulse,
  output logic              motor_dir,
  output logic [7:0]        dir_setting
);

  // Two-stage synchronisers for every pin from outside this clock domain.
  logic [1:0] sclk_sync;       // Serial clock synchroniser.
  logic [1:0] cs_sync;         // Chip select synchroniser.
  logic [1:0] mosi_sync;       // Serial data synchroniser.
  logic [1:0] run_sync;        // Run/halt synchroniser.
  logic [1:0] dir_sync;        // Direction pin synchroniser.
  logic       sclk_prev;       // Previous synchronised serial clock level.

  // Serial slave state.
  logic [15:0] shift;          // Receive shift register.
  logic [4:0]  bit_count;      // Bits received in this frame.
  logic [7:0]  tx;             // Return-line shift register.
  logic        miso_bit;       // Registered return-line data.
  logic        miso_en;        // Registered return-line enable.
  logic [7:0]  params [mrdsc_pkg::PARAM_COUNT]; // Parameter storage, one byte per slot.

  // Next values.
  logic [15:0] next_shift;
  logic [4:0]  next_bit_count;
  logic [7:0]  next_tx;
  logic        next_miso_bit;
  logic        next_miso_en;
  logic [7:0]  next_params [mrdsc_pkg::PARAM_COUNT];
  logic        next_step_enable;
  logic        next_step_pulse;
  logic        next_motor_dir;

  // Next values of the synchronisers and of the edge detector.
  logic [1:0]  next_sclk_sync;  // Serial clock stages.
  logic [1:0]  next_cs_sync;    // Chip select stages.
  logic [1:0]  next_mosi_sync;  // Serial data stages.
  logic [1:0]  next_run_sync;   // Run/halt stages.
  logic [1:0]  next_dir_sync;   // Direction pin stages.
  logic        next_sclk_prev;  // Serial clock level for edge finding.

  // Edge events seen by the system clock.
  logic selected;
  logic rise;
  logic fall;

  // Shift every pin into its first stage. Only the second stage is read past this
  // point, so a metastable first stage never reaches the decoding logic.
  always_comb
  begin
    next_sclk_sync = {sclk_sync[0], link.sclk};
    next_cs_sync   = {cs_sync[0], link.cs_n};
    next_mosi_sync = {mosi_sync[0], link.mosi};
    next_run_sync  = {run_sync[0], run_halt_n};
    next_dir_sync  = {dir_sync[0], dir_in};
    next_sclk_prev = sclk_sync[1];
  end

  // Register the synchronisers. Reset values match the idle pin levels, so no
  // false edge and no false select follows reset.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_sync <= 2'h0;   // Serial clock idles low.
      cs_sync   <= 2'h3;   // Deselected.
      mosi_sync <= 2'h0;
      run_sync  <= 2'h3;   // Halted, as with a floating pin.
      dir_sync  <= 2'h0;
      sclk_prev <= 1'b0;
    end
    else
    begin
      sclk_sync <= next_sclk_sync;
      cs_sync   <= next_cs_sync;
      mosi_sync <= next_mosi_sync;
      run_sync  <= next_run_sync;
      dir_sync  <= next_dir_sync;
      sclk_prev <= next_sclk_prev;
    end
  end

  // Edges are found by sampling, so any clock slower than a few system clocks works.
  // Each serial level must last at least one system clock or an edge is lost; the
  // limit comes from this detector, not from the master.
  assign selected = ~cs_sync[1];                        // [R8]
  assign rise     = selected & sclk_sync[1] & ~sclk_prev; // [R3] [R4]
  assign fall     = selected & ~sclk_sync[1] & sclk_prev; // [R3] [R4]

  // Next state of the serial slave and of the motor outputs.
  always_comb
  begin
    next_shift     = shift;
    next_bit_count = bit_count;
    next_tx        = tx;
    next_miso_bit  = miso_bit;
    next_miso_en   = selected;                          // [R5] [R10]
    next_params    = params;
    if (!selected)
    begin
      // Deselect aborts a partial frame; a half-written value is never stored.
      // The return enable follows the select, so the line is released as well.
      next_bit_count = mrdsc_pkg::COUNT_RESET;          // [R10]
      next_miso_bit  = 1'b0;
    end
    else if (rise)
    begin
      // Sample the data line on each rising edge, most significant bit first.
      next_shift     = {shift[14:0], mosi_sync[1]};     // [R7]
      next_bit_count = bit_count + 5'h01;
      if (bit_count == 5'(mrdsc_pkg::FRAME_BITS - 1) && !shift[mrdsc_pkg::CMD_READ_POS - 1])
      begin
        // Last bit of a write frame: frame bit k sits at shift[k-1] here, so the
        // index is shift[9:7] and the data byte is shift[6:0] plus the new bit.
        // A read frame never reaches this store, since its flag bit is set.
        next_params[shift[mrdsc_pkg::CMD_INDEX_LSB + mrdsc_pkg::INDEX_BITS - 2 -:
                          mrdsc_pkg::INDEX_BITS]] = {shift[6:0], mosi_sync[1]}; // [R7]
      end
      if (bit_count == 5'(mrdsc_pkg::DATA_BITS - 1))
      begin
        // Command byte complete: load the addressed value for return.
        next_tx = params[{shift[1:0], mosi_sync[1]}];   // [R6]
      end
    end
    else if (fall && bit_count >= 5'(mrdsc_pkg::DATA_BITS)
             && bit_count < 5'(mrdsc_pkg::FRAME_BITS))
    begin
      // Present the next return bit after each falling edge. The master samples
      // late in the following high half, which covers this path's latency.
      next_miso_bit = tx[7];                            // [R6] [R3]
      next_tx       = {tx[6:0], 1'b0};
    end
    // Halt wins while the pin is high or floating high.
    next_step_enable = ~run_sync[1];                    // [R1]
    next_step_pulse  = ~run_sync[1] & step_tick;        // [R1]
    // Flipping the pin flips the axis whatever the stored setting is.
    next_motor_dir   = dir_sync[1] ^ params[mrdsc_pkg::DIR_SLOT][mrdsc_pkg::DIR_BIT]; // [R2]
  end

  // Register the slave state and outputs.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      shift       <= 16'h0000;
      bit_count   <= mrdsc_pkg::COUNT_RESET;
      tx          <= 8'h00;
      miso_bit    <= 1'b0;
      miso_en     <= 1'b0;   // The return line is released during reset.
      step_enable <= 1'b0;   // The generator is halted during reset.
      step_pulse  <= 1'b0;
      motor_dir   <= 1'b0;
      // Every slot comes up cleared, so the stored direction starts at zero.
      // Settings do not survive a reset; the master must write them again.
      for (int i = 0; i < mrdsc_pkg::PARAM_COUNT; i++)
      begin
        params[i] <= mrdsc_pkg::PARAM_RESET;
      end
    end
    else
    begin
      shift       <= next_shift;
      bit_count   <= next_bit_count;
      tx          <= next_tx;
      miso_bit    <= next_miso_bit;
      miso_en     <= next_miso_en;
      step_enable <= next_step_enable;
      step_pulse  <= next_step_pulse;
      motor_dir   <= next_motor_dir;
      params      <= next_params;
    end
  end

  // The return line and its enable come straight from flip-flops, so no glitch
  // reaches the shared line while another unit may be driving it.
  assign link.miso_out = miso_bit;
  assign link.miso_oe  = miso_en;
  assign dir_setting   = params[mrdsc_pkg::DIR_SLOT];

endmodule : mrdsc_device

// [hdl/mrdsc_pkg.sv]
// Shared constants and types for the motor run/direction block and its serial link.
package mrdsc_pkg;

  // Width of one serial frame: command byte followed by data byte.
  localparam int unsigned FRAME_BITS = 16;
  // Number of configuration parameter slots held by the device.
  localparam int unsigned PARAM_COUNT = 8;
  // Width of a slot index.
  localparam int unsigned INDEX_BITS = 3;
  // Width of one parameter value.
  localparam int unsigned DATA_BITS = 8;
  // Position of the read flag inside the command byte.
  localparam int unsigned CMD_READ_POS = 15;
  // Lowest bit of the slot index inside the command byte.
  localparam int unsigned CMD_INDEX_LSB = 8;
  // Slot that holds the stored direction setting.
  localparam logic [2:0] DIR_SLOT = 3'h0;
  // Bit of the direction slot that holds the stored direction.
  localparam int unsigned DIR_BIT = 0;
  // Value of every parameter slot after reset.
  localparam logic [7:0] PARAM_RESET = 8'h00;
  // Master divider: system clocks per half period of the serial clock.
  localparam logic [7:0] HALF_PERIOD_DEFAULT = 8'h04;
  // Reset value of the bit counters.
  localparam logic [4:0] COUNT_RESET = 5'h00;

  // Master sequencer states.
  typedef enum logic [1:0] {
    MRDSC_IDLE,
    MRDSC_LOW,
    MRDSC_HIGH,
    MRDSC_DONE
  } mrdsc_state_t;

endpackage : mrdsc_pkg

// [hdl/mrdsc_link_if.sv]
// Serial link between one configuration master and one motor device.
interface mrdsc_link_if;

  logic sclk;      // Serial clock driven by the master.
  logic cs_n;      // Chip select, active low, driven by the master.
  logic mosi;      // Data from master to device.
  logic miso_out;  // Device data toward the master.
  logic miso_oe;   // High while the device drives the return line.

  // Master end of the link.
  modport master (
    output sclk,
    output cs_n,
    output mosi,
    input  miso_out,
    input  miso_oe
  );

  // Device end of the link.
  modport device (
    input  sclk,
    input  cs_n,
    input  mosi,
    output miso_out,
    output miso_oe
  );

endinterface : mrdsc_link_if

// [hdl/mrdsc_master.sv]
// Master end: frames one read or write to a device, deriving the serial clock.
module mrdsc_master (
  input  wire logic         clk,
  input  wire logic         reset,
  mrdsc_link_if.master      link,
  input  wire logic         start,
  input  wire logic         read,
  input  wire logic [2:0]   index,
  input  wire logic [7:0]   wdata,
  input  wire logic [7:0]   half_period,
  output logic              busy,
  output logic              done,
  output logic [7:0]        rdata
);

  mrdsc_pkg::mrdsc_state_t state;      // Sequencer state.
  mrdsc_pkg::mrdsc_state_t next_state;
  logic [7:0]  div;                    // Half-period divider.
  logic [7:0]  next_div;
  logic [15:0] tx;                     // Outgoing frame.
  logic [15:0] next_tx;
  logic [4:0]  bits;                   // Bits clocked so far.
  logic [4:0]  next_bits;
  logic [7:0]  rx;                     // Incoming data.
  logic [7:0]  next_rx;
  logic [1:0]  miso_sync;              // Return data synchroniser.
  logic        sclk_q, cs_q, mosi_q;   // Registered pins.
  logic        next_sclk, next_cs, next_mosi;
  logic        next_busy, next_done;
  logic [7:0]  next_rdata;
  logic        tick;                   // Half-period enable pulse.

  // One-cycle enable from the divider; zero is treated as the default rate.
  assign tick = (div == 8'h00);

  // Sequencer: one frame with the select held low throughout.
  always_comb
  begin
    next_state = state;
    next_div   = tick ? ((half_period == 8'h00) ? mrdsc_pkg::HALF_PERIOD_DEFAULT
                                                : half_period) - 8'h01 : div - 8'h01;
    next_tx    = tx;
    next_bits  = bits;
    next_rx    = rx;
    next_sclk  = sclk_q;
    next_cs    = cs_q;
    next_mosi  = mosi_q;
    next_busy  = busy;
    next_done  = 1'b0;
    next_rdata = rdata;
    unique case (state)
      mrdsc_pkg::MRDSC_IDLE:
      begin
        if (start)
        begin
          // Only this unit's select falls for the frame.
          next_tx    = {read, 4'h0, index, read ? 8'h00 : wdata}; // [R9] [R5]
          next_cs    = 1'b0;
          next_mosi  = read;
          next_bits  = mrdsc_pkg::COUNT_RESET;
          next_busy  = 1'b1;
          next_div   = mrdsc_pkg::HALF_PERIOD_DEFAULT;
          next_state = mrdsc_pkg::MRDSC_LOW;
        end
      end
      mrdsc_pkg::MRDSC_LOW:
      begin
        if (tick)
        begin
          // Rising edge: the device samples the data line.
          next_sclk  = 1'b1;                           // [R3]
          next_state = mrdsc_pkg::MRDSC_HIGH;
        end
      end
      mrdsc_pkg::MRDSC_HIGH:
      begin
        if (tick)
        begin
          next_sclk = 1'b0;
          next_bits = bits + 5'h01;
          // Take the return bit at the end of the high half: the device answers three
          // clocks after a fall and the synchroniser adds two, more than a four-clock
          // low half leaves before the rise.
          next_rx   = {rx[6:0], miso_sync[1]};          // [R6]
          next_tx   = {tx[14:0], 1'b0};
          next_mosi = tx[14];                          // [R7]
          next_state = (bits == 5'(mrdsc_pkg::FRAME_BITS - 1)) ? mrdsc_pkg::MRDSC_DONE
                                                               : mrdsc_pkg::MRDSC_LOW;
        end
      end
      mrdsc_pkg::MRDSC_DONE:
      begin
        if (tick)
        begin
          next_cs    = 1'b1;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_rdata = rx;                             // [R6]
          next_state = mrdsc_pkg::MRDSC_IDLE;
        end
      end
    endcase
  end

  // Register the sequencer and the pins.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state     <= mrdsc_pkg::MRDSC_IDLE;
      div       <= mrdsc_pkg::HALF_PERIOD_DEFAULT;
      tx        <= 16'h0000;
      bits      <= mrdsc_pkg::COUNT_RESET;
      rx        <= 8'h00;
      miso_sync <= 2'h0;
      sclk_q    <= 1'b0;
      cs_q      <= 1'b1;
      mosi_q    <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      rdata     <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      div       <= next_div;
      tx        <= next_tx;
      bits      <= next_bits;
      rx        <= next_rx;
      miso_sync <= {miso_sync[0], link.miso_oe & link.miso_out};
      sclk_q    <= next_sclk;
      cs_q      <= next_cs;
      mosi_q    <= next_mosi;
      busy      <= next_busy;
      done      <= next_done;
      rdata     <= next_rdata;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.mosi = mosi_q;

endmodule : mrdsc_master

// [tb/mrdsc_link_assertions.sv]
// Checker for the serial link between the two ends.
module mrdsc_link_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] rises;      // Serial clock rises in this frame.
  logic [4:0] next_rises; // Next value of the count.
  logic       sclk_d;     // Serial clock one cycle ago.
  // A deselect clears the count, so a short frame shows up.
  always_comb
  begin
    next_rises = cs_n ? 5'h00 : rises + {4'h0, sclk & ~sclk_d};
  end
  // Register the count and the delayed clock.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rises  <= 5'h00;
      sclk_d <= 1'b0;
    end
    else
    begin
      rises  <= next_rises;
      sclk_d <= sclk;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  bit_count_a: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("frame clock count wrong");
  frame_len_a: assert property ($fell(cs_n) |-> ##[100:600] $rose(cs_n))
    else $error("frame length out of bounds");
  high_half_a: assert property ($rose(sclk) |=> sclk[*3])
    else $error("serial clock high half too short");
  low_half_a: assert property ($fell(sclk) && !cs_n |=> (!sclk)[*3])
    else $error("serial clock low half too short");
  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("serial clock runs while deselected");
  oe_release_a: assert property (cs_n[*4] |-> !miso_oe)
    else $error("return line driven while deselected");
  oe_drive_a: assert property ((!cs_n)[*6] |-> miso_oe)
    else $error("return line not driven in frame");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed in clock high half");
endmodule : mrdsc_link_assertions

// [tb/tb_top.sv]
// Bench top: both link ends joined, driven through frame tasks.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;         // System clock, 100 ns.
  logic       reset;       // Synchronous reset.
  logic       start;       // Frame request.
  logic       read;        // High for a read.
  logic [2:0] index;       // Slot index.
  logic [7:0] wdata;       // Write value.
  logic [7:0] half_period; // Clocks per serial half period.
  logic       busy;        // Master busy.
  logic       done;        // Frame finished.
  logic [7:0] rdata;       // Read value.
  logic       run_halt_n;  // Run pin, low runs.
  logic       dir_in;      // Direction pin.
  logic       step_tick;   // Speed tick.
  logic       step_enable; // Generator running.
  logic       step_pulse;  // Gated tick.
  logic       motor_dir;   // Resulting direction.
  logic [7:0] dir_setting; // Slot zero.
  int         mismatches;  // Failed compares.
  int         n_compared;  // All compares.
  int         cycles;      // Clock count for the hang guard.
  mrdsc_link_if link_bus ();
  mrdsc_master mrdsc_master_inst (
    .clk         (clk),
    .reset       (reset),
    .link        (link_bus),
    .start       (start),
    .read        (read),
    .index       (index),
    .wdata       (wdata),
    .half_period (half_period),
    .busy        (busy),
    .done        (done),
    .rdata       (rdata)
  );
  mrdsc_device mrdsc_device_inst (
    .clk         (clk),
    .reset       (reset),
    .link        (link_bus),
    .run_halt_n  (run_halt_n),
    .dir_in      (dir_in),
    .step_tick   (step_tick),
    .step_enable (step_enable),
    .step_pulse  (step_pulse),
    .motor_dir   (motor_dir),
    .dir_setting (dir_setting)
  );
  mrdsc_link_assertions mrdsc_link_assertions_inst (
    .clk      (clk),
    .reset    (reset),
    .sclk     (link_bus.sclk),
    .cs_n     (link_bus.cs_n),
    .mosi     (link_bus.mosi),
    .miso_out (link_bus.miso_out),
    .miso_oe  (link_bus.miso_oe)
  );
  // Count a compare and report a difference at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One frame; the request stands one clock, then wait for done.
  task automatic frame(input logic rd, input logic [2:0] idx,
                       input logic [7:0] wd, input logic [7:0] hp);
    @(posedge clk);
    start       <= 1'b1;
    read        <= rd;
    index       <= idx;
    wdata       <= wd;
    half_period <= hp;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk({7'h00, busy}, 8'h01);
    // The global guard bounds this wait.
    while (done !== 1'b1)
      @(posedge clk);
    chk({7'h00, busy}, 8'h00);
  endtask : frame
  // Print the verdict and stop.
  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  always #50 clk = ~clk;
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    clk = 1'b0; reset = 1'b1; start = 1'b0; read = 1'b0;
    index = 3'h0; wdata = 8'h00; half_period = 8'h04;
    run_halt_n = 1'b1; dir_in = 1'b0; step_tick = 1'b0;
    mismatches = 0; n_compared = 0; cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, link_bus.cs_n}, 8'h01);
    chk(dir_setting, 8'h00);
    // Fill every slot, then read back at three serial rates and the default one.
    for (int i = 0; i < 8; i++)
      frame(1'b0, 3'(i), 8'h5a ^ 8'(i * 17), 8'h04);
    chk(dir_setting, 8'h5a);
    for (int i = 0; i < 8; i++)
    begin
      // A zero half period selects the master's default rate.
      frame(1'b1, 3'(i), 8'h00, (i == 0) ? 8'h00 : 8'(4 + 2 * (i % 3)));
      chk(rdata, 8'h5a ^ 8'(i * 17));
    end
    // Both stored settings against both pin levels.
    for (int s = 0; s < 2; s++)
    begin
      frame(1'b0, 3'h0, 8'(s), 8'h08);
      for (int d = 0; d < 2; d++)
      begin
        dir_in <= 1'(d);
        repeat (5) @(posedge clk);
        chk({7'h00, motor_dir}, 8'(d ^ s));
      end
    end
    // Run and halt, each with one tick offered.
    for (int r = 0; r < 2; r++)
    begin
      run_halt_n <= 1'(r);
      repeat (5) @(posedge clk);
      chk({7'h00, step_enable}, 8'(1 - r));
      step_tick <= 1'b1;
      @(posedge clk);
      step_tick <= 1'b0;
      @(posedge clk);
      chk({7'h00, step_pulse}, 8'(1 - r));
    end
    end_of_test();
  end
endmodule : tb_top
